// ---- rtl/cfg_key_defs.svh ----
// Constants for the configuration port key state machine.
`ifndef CFG_KEY_DEFS_SVH
`define CFG_KEY_DEFS_SVH
`define CFG_ENTRY_KEY 8'h55
`define CFG_EXIT_KEY 8'hAA
`define CFG_BASE_STRAP_LO 16'h002E
`define CFG_BASE_STRAP_HI 16'h004E
`define CFG_DATA_OFFSET 16'h0001
`define CFG_IDX_LDN 8'h07
`define CFG_IDX_ADDR_LOW 8'h26
`define CFG_IDX_ADDR_HIGH 8'h27
`define CFG_IDX_DEV_ID 8'h20
`define CFG_IDX_ACTIVATE 8'h30
`define CFG_NUM_LDN 16
`define CFG_BYTE_ZERO 8'h00
`define CFG_LDN_PAD 4'h0
`define CFG_DEV_ID_VALUE 8'hA5
`endif

// ---- rtl/cfg_key_pkg.sv ----
// Types shared by the configuration port logic.
package cfg_key_pkg;
	typedef enum logic {ST_RUN, ST_CONFIG} cfg_state_t;
endpackage : cfg_key_pkg

// ---- rtl/activate_bank.sv ----
// Per-logical-device activate bits, one byte each, with registered read data.
`timescale 1ns/1ps
`include "cfg_key_defs.svh"
module activate_bank (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic soft_clr_i,
	// Write and read port.
	input wire logic we_i,
	input wire logic [3:0] ldn_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic [15:0] active_o
);
	typedef struct packed {
		logic [`CFG_NUM_LDN-1:0][7:0] mem;
		logic [7:0] rdata;
	} bank_t;
	bank_t s_q, s_d;

	// All devices come up disabled after either reset.
	always_comb begin
		s_d = s_q;
		if (soft_clr_i) begin
			s_d.mem = '0;
		end else if (we_i) begin
			s_d.mem[ldn_i] = wdata_i;
		end
		s_d.rdata = s_d.mem[ldn_i];
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_o = s_q.rdata;
	// Activate is bit 0 of each device's byte.
	always_comb begin
		for (int i = 0; i < `CFG_NUM_LDN; i++) begin
			active_o[i] = s_q.mem[i][0];
		end
	end
endmodule : activate_bank

// ---- rtl/cfg_port_key.sv ----
// Configuration key state machine with index/data port decode.
`timescale 1ns/1ps
`include "cfg_key_defs.svh"
module cfg_port_key (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Host reset pin and shared strap/GPIO pin.
	input wire logic host_reset_n_i,
	input wire logic shared_gpio_pin_i,
	// Host I/O cycle, one-cycle strobes from the bus decoder.
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [15:0] io_addr_i,
	input wire logic [7:0] io_wdata_i,
	// Read answer.
	output logic [7:0] io_rdata_o,
	output logic io_rd_hit_o,
	// Status and controls.
	output logic in_config_o,
	output logic [15:0] ldn_active_o,
	output logic gpio_in_o,
	output logic [15:0] cfg_base_o
);
	typedef struct packed {
		logic [1:0] rst_sync;
		logic [1:0] pin_sync;
		logic strap;
		logic clr_pend;
		cfg_key_pkg::cfg_state_t state;
		logic [7:0] index;
		logic [3:0] ldn;
		logic [7:0] addr_low;
		logic [7:0] addr_high;
		logic [7:0] rdata;
		logic rd_hit;
		logic gpio_in;
	} cfg_s_t;
	cfg_s_t s_q, s_d;

	logic [15:0] base;
	logic key_hit;
	logic data_hit;
	logic bank_we;
	logic [7:0] bank_rdata;
	logic [7:0] dev_id;

	// Identity value is arbitrary.
	assign dev_id = `CFG_DEV_ID_VALUE;
	assign base = {s_q.addr_high, s_q.addr_low};
	assign key_hit = io_addr_i == base;
	assign data_hit = io_addr_i == (base + `CFG_DATA_OFFSET);
	assign bank_we = io_wr_i && data_hit && (s_q.state == cfg_key_pkg::ST_CONFIG)
		&& (s_q.index == `CFG_IDX_ACTIVATE);

	// Next-state logic; host reset seen low restarts the block.
	// The host reset pin and the strap pin pass two flops each before any decision.
	// Both chains have the same depth, so the strap seen with the last low reset
	// sample belongs to the same instant as that reset sample.
	// A key write and a data write can never hit together, since the data port
	// always sits one address above the key port.
	always_comb begin
		s_d = s_q;
		s_d.rst_sync = {s_q.rst_sync[0], host_reset_n_i};
		s_d.pin_sync = {s_q.pin_sync[0], shared_gpio_pin_i};
		s_d.gpio_in = s_q.pin_sync[1];
		s_d.rd_hit = 1'b0; // The read answer is a one-cycle pulse.
		s_d.clr_pend = 1'b0;
		if (!s_q.rst_sync[1]) begin
			// Strap is re-latched while the host reset is held, last value wins at release.
			s_d.state = cfg_key_pkg::ST_RUN;
			s_d.strap = s_q.pin_sync[1];
			// Only the low byte of the strap base is held here; the high byte is zero.
			s_d.addr_low = s_q.pin_sync[1] ? 8'(`CFG_BASE_STRAP_HI) : 8'(`CFG_BASE_STRAP_LO);
			s_d.addr_high = `CFG_BYTE_ZERO;
			s_d.index = `CFG_BYTE_ZERO;
			s_d.ldn = '0;
			s_d.clr_pend = 1'b1;
		end else begin
			case (s_q.state)
				cfg_key_pkg::ST_RUN: begin
					if (io_wr_i && key_hit && io_wdata_i == `CFG_ENTRY_KEY) begin
						s_d.state = cfg_key_pkg::ST_CONFIG;
					end // Any other byte is dropped.
				end
				cfg_key_pkg::ST_CONFIG: begin
					// The exit key is never stored as an index, so index 0xAA is unreachable.
					// A write wins over a read in the same cycle; the bus never issues both.
					if (io_wr_i && key_hit) begin
						if (io_wdata_i == `CFG_EXIT_KEY) begin
							s_d.state = cfg_key_pkg::ST_RUN;
						end else begin
							s_d.index = io_wdata_i;
						end
					end else if (io_wr_i && data_hit) begin
						case (s_q.index)
							`CFG_IDX_LDN: s_d.ldn = io_wdata_i[3:0];
							`CFG_IDX_ADDR_LOW: s_d.addr_low = io_wdata_i;
							`CFG_IDX_ADDR_HIGH: s_d.addr_high = io_wdata_i;
							default: s_d.ldn = s_q.ldn;
						endcase
					end else if (io_rd_i && (key_hit || data_hit)) begin
						s_d.rd_hit = 1'b1;
						if (key_hit) begin
							s_d.rdata = s_q.index;
						end else begin
							case (s_q.index)
								`CFG_IDX_LDN: s_d.rdata = {`CFG_LDN_PAD, s_q.ldn};
								`CFG_IDX_ADDR_LOW: s_d.rdata = s_q.addr_low;
								`CFG_IDX_ADDR_HIGH: s_d.rdata = s_q.addr_high;
								`CFG_IDX_DEV_ID: s_d.rdata = dev_id;
								// The bank register already holds the selected device's byte.
								`CFG_IDX_ACTIVATE: s_d.rdata = bank_rdata;
								default: s_d.rdata = `CFG_BYTE_ZERO;
							endcase
						end
					end
				end
				default: s_d.state = cfg_key_pkg::ST_RUN;
			endcase
		end
	end

	// Power-on reset gives the strap-low base; the strap is re-read once the reset is released.
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
			s_q.state <= cfg_key_pkg::ST_RUN;
			s_q.addr_low <= 8'(`CFG_BASE_STRAP_LO);
			s_q.clr_pend <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	activate_bank u_bank (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.soft_clr_i(s_q.clr_pend),
		.we_i(bank_we),
		.ldn_i(s_q.ldn),
		.wdata_i(io_wdata_i),
		.rdata_o(bank_rdata),
		.active_o(ldn_active_o)
	);

	// Read data leaves straight from its register, so the host sees no mux glitch.
	// Activate reads are copied into that register at the same edge that samples the strobe, as all other reads are.
	assign io_rdata_o = s_q.rdata;
	assign io_rd_hit_o = s_q.rd_hit;
	assign in_config_o = s_q.state == cfg_key_pkg::ST_CONFIG;
	assign gpio_in_o = s_q.gpio_in;
	assign cfg_base_o = base;

	// Checks on the key sequence.
	a_entry_key: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(s_q.rst_sync[1] && s_q.state == cfg_key_pkg::ST_RUN && io_wr_i && key_hit
		&& io_wdata_i == `CFG_ENTRY_KEY) |=> in_config_o) else $error("entry key missed");
	a_exit_key: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(s_q.rst_sync[1] && in_config_o && io_wr_i && key_hit && io_wdata_i == `CFG_EXIT_KEY)
		|=> !in_config_o) else $error("exit key missed");
	a_run_ignore: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(s_q.rst_sync[1] && !in_config_o && !(io_wr_i && key_hit && io_wdata_i == `CFG_ENTRY_KEY))
		|=> !in_config_o && $stable(s_q.index)) else $error("run state changed");
	a_run_noread: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!in_config_o |=> !io_rd_hit_o) else $error("read answered in run");
	a_host_reset: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!s_q.rst_sync[1] |=> !in_config_o ##1 (ldn_active_o == '0)) else $error("reset state wrong");
	a_strap_base: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!s_q.rst_sync[1] |=> cfg_base_o == ($past(s_q.pin_sync[1]) ? `CFG_BASE_STRAP_HI
		: `CFG_BASE_STRAP_LO)) else $error("strap base wrong");
	a_relocate: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(s_q.rst_sync[1] && in_config_o && io_wr_i && data_hit && s_q.index == `CFG_IDX_ADDR_LOW)
		|=> cfg_base_o[7:0] == $past(io_wdata_i)) else $error("relocation failed");
	a_gpio_path: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		1'b1 |-> ##3 gpio_in_o == $past(shared_gpio_pin_i, 3)) else $error("gpio path broken");

	// Checks on the index and data ports while configuring, and on data port writes in Run.
	// Every antecedent asks for a released host reset, since a held reset
	// overrides all port traffic and would make these checks fire falsely.
	// A key write other than the exit key lands in the index register.
	a_index_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(s_q.rst_sync[1] && in_config_o && io_wr_i && key_hit && io_wdata_i != `CFG_EXIT_KEY)
		|=> s_q.index == $past(io_wdata_i)) else $error("index write lost");
	// A data write under index 0x07 selects the logical device.
	a_ldn_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(s_q.rst_sync[1] && in_config_o && io_wr_i && data_hit && s_q.index == `CFG_IDX_LDN)
		|=> s_q.ldn == $past(io_wdata_i[3:0])) else $error("device select lost");
	// The high address byte relocates the port as the low byte does.
	a_relocate_high: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(s_q.rst_sync[1] && in_config_o && io_wr_i && data_hit && s_q.index == `CFG_IDX_ADDR_HIGH)
		|=> cfg_base_o[15:8] == $past(io_wdata_i)) else $error("high relocation failed");
	// Every read of either port in Configuration with no write in the same cycle is answered on the next cycle.
	a_read_answer: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(s_q.rst_sync[1] && in_config_o && io_rd_i && !io_wr_i && (key_hit || data_hit))
		|=> io_rd_hit_o) else $error("read not answered");
	// Reading the index port returns the current index.
	a_read_index: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(s_q.rst_sync[1] && in_config_o && io_rd_i && !io_wr_i && key_hit)
		|=> io_rdata_o == $past(s_q.index)) else $error("index read wrong");
	// The identity register reads its fixed value.
	a_read_ident: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(s_q.rst_sync[1] && in_config_o && io_rd_i && !io_wr_i && data_hit
		&& s_q.index == `CFG_IDX_DEV_ID) |=> io_rdata_o == `CFG_DEV_ID_VALUE) else $error("ident read wrong");
	// In Run a data port write must not reach any register.
	a_run_nowrite: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(s_q.rst_sync[1] && !in_config_o && io_wr_i && data_hit)
		|=> $stable(cfg_base_o) && $stable(s_q.ldn) && $stable(ldn_active_o)) else $error("run write landed");
	c_enter: cover property (@(posedge mclk_i) !in_config_o ##1 in_config_o);
	c_exit: cover property (@(posedge mclk_i) in_config_o ##1 !in_config_o);
	c_activate: cover property (@(posedge mclk_i) bank_we);
	c_strap_hi: cover property (@(posedge mclk_i) cfg_base_o == `CFG_BASE_STRAP_HI);
	c_read: cover property (@(posedge mclk_i) io_rd_hit_o);
endmodule : cfg_port_key

// ---- tb/host_bus_model.sv ----
// Host bus master model that issues one-cycle I/O strobes.
`timescale 1ns/1ps
module host_bus_model (
	// Clock.
	input wire logic mclk_i,
	// Strobes towards the block.
	output logic io_wr_o,
	output logic io_rd_o,
	output logic [15:0] io_addr_o,
	output logic [7:0] io_wdata_o,
	// Read answer.
	input wire logic io_rd_hit_i,
	input wire logic [7:0] io_rdata_i
);
	// The bus starts idle.
	initial begin
		io_wr_o = 1'b0;
		io_rd_o = 1'b0;
		io_addr_o = 16'hFFFF;
		io_wdata_o = 8'hFF;
	end
	// One write, held over exactly one rising edge.
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		io_addr_o = a;
		io_wdata_o = d;
		io_wr_o = 1'b1;
		@(negedge mclk_i);
		io_wr_o = 1'b0;
		io_addr_o = ~a; // Released lines never show a stale value.
		io_wdata_o = ~d;
	endtask : wr
	// One read; the answer is awaited over three falling edges.
	task automatic rd(input logic [15:0] a, output logic h, output logic [7:0] d);
		@(negedge mclk_i);
		io_addr_o = a;
		io_rd_o = 1'b1;
		h = 1'b0;
		d = 8'h00;
		repeat (3) begin
			@(negedge mclk_i);
			io_rd_o = 1'b0;
			io_addr_o = ~a;
			if (io_rd_hit_i === 1'b1) begin
				h = 1'b1;
				d = io_rdata_i;
			end
		end
	endtask : rd
endmodule : host_bus_model

// ---- tb/config_port_key_state_machine_bench.sv ----
// Self-checking bench for the configuration key state machine.
`timescale 1ns/1ps
module config_port_key_state_machine_bench;
	logic mclk_i, sys_rst_i, host_reset_n_i, shared_gpio_pin_i, io_wr, io_rd, hit_o, cfg_o, gpio_o, hit;
	logic [15:0] addr, act_o, base_o;
	logic [7:0] wdata, rdata_o, rdat;
	int err_count = 0;
	int num_checks = 0;
	host_bus_model host (.mclk_i(mclk_i), .io_wr_o(io_wr), .io_rd_o(io_rd), .io_addr_o(addr),
		.io_wdata_o(wdata), .io_rd_hit_i(hit_o), .io_rdata_i(rdata_o));
	cfg_port_key DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .host_reset_n_i(host_reset_n_i),
		.shared_gpio_pin_i(shared_gpio_pin_i), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_addr_i(addr),
		.io_wdata_i(wdata), .io_rdata_o(rdata_o), .io_rd_hit_o(hit_o), .in_config_o(cfg_o),
		.ldn_active_o(act_o), .gpio_in_o(gpio_o), .cfg_base_o(base_o));
	// Free-running 250 MHz clock.
	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end
	// Compares one value and counts the result.
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Prints the counts and the verdict, then stops.
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	// Reads one port; data is only judged when an answer is expected.
	task automatic rd_chk(input logic [15:0] a, input logic h, input logic [7:0] d);
		host.rd(a, hit, rdat);
		chk("rd_hit", 16'(h), 16'(hit));
		if (h) chk("rd_data", 16'(d), 16'(rdat));
	endtask : rd_chk
	// In Run only the entry key counts, and reads go unanswered.
	task automatic t_run_ignore;
		host.wr(16'h004E, 8'hAA);
		host.wr(16'h004E, 8'h07);
		chk("in_config", 16'h0000, 16'(cfg_o));
		rd_chk(16'h004F, 1'b0, 8'h00);
		rd_chk(16'h004E, 1'b0, 8'h00);
		$display("test run_ignore done");
	endtask : t_run_ignore
	// Enter, pick device 2, activate it and read back the activate byte and device number through the data port.
	task automatic t_config(input logic [15:0] b);
		host.wr(b, 8'h55);
		chk("in_config", 16'h0001, 16'(cfg_o));
		host.wr(b, 8'h07);
		host.wr(b + 16'h0001, 8'h02);
		host.wr(b, 8'h30);
		host.wr(b + 16'h0001, 8'h01);
		chk("active", 16'h0004, act_o);
		rd_chk(b + 16'h0001, 1'b1, 8'h01);
		host.wr(b, 8'h07);
		rd_chk(b + 16'h0001, 1'b1, 8'h02);
		$display("test config done");
	endtask : t_config
	// Move the port, leave, and show the old address is dead.
	task automatic t_relocate;
		host.wr(16'h004E, 8'h26);
		host.wr(16'h004F, 8'h60);
		chk("base", 16'h0060, base_o);
		host.wr(16'h0060, 8'hAA);
		chk("in_config", 16'h0000, 16'(cfg_o));
		host.wr(16'h004E, 8'h55);
		chk("in_config", 16'h0000, 16'(cfg_o));
		$display("test relocate done");
	endtask : t_relocate
	// A host reset with the strap low, then the pin serves as plain input.
	task automatic t_hard_reset;
		host.wr(16'h0060, 8'h55);
		shared_gpio_pin_i = 1'b0;
		host_reset_n_i = 1'b0;
		repeat (4) @(negedge mclk_i);
		host_reset_n_i = 1'b1;
		shared_gpio_pin_i = 1'b1;
		repeat (5) @(negedge mclk_i);
		chk("base", 16'h002E, base_o);
		chk("gpio", 16'h0001, 16'(gpio_o));
		chk("in_config", 16'h0000, 16'(cfg_o));
		chk("active", 16'h0000, act_o);
		host.wr(16'h002E, 8'h55);
		chk("in_config", 16'h0001, 16'(cfg_o));
		host.wr(16'h002E, 8'hAA);
		chk("in_config", 16'h0000, 16'(cfg_o));
		$display("test hard_reset done");
	endtask : t_hard_reset
	// Power-up with the strap high, then the tests in order.
	initial begin
		sys_rst_i = 1'b1;
		host_reset_n_i = 1'b0;
		shared_gpio_pin_i = 1'b1;
		repeat (4) @(negedge mclk_i);
		sys_rst_i = 1'b0;
		repeat (2) @(negedge mclk_i);
		host_reset_n_i = 1'b1;
		repeat (4) @(negedge mclk_i);
		chk("base", 16'h004E, base_o);
		chk("in_config", 16'h0000, 16'(cfg_o));
		chk("active", 16'h0000, act_o);
		t_run_ignore();
		t_config(16'h004E);
		t_relocate();
		t_hard_reset();
		complete_run();
	end
	// The tests need under a hundred cycles; this cuts a hang short.
	initial begin
		#40000;
		err_count++;
		complete_run();
	end
endmodule : config_port_key_state_machine_bench
